// ===== adcop_port.v
// Output port of an eight-bit pipelined converter
// What this block does
// - Sample on converter clock fall; result appears 2.5 cycles plus output delay later.
// - A new output word every converter clock cycle, fixed pipeline lag.
// - In-range inputs become eight-bit words, rates up to 55 MSPS.
// - Input below bottom reference gives an all-zero word.
// - Input above top reference gives an all-ones word.
// - Converts continuously while a clock runs; no start command needed.
// - Power-down pin high enters low-power mode below 5 mW.
// - While powered down, dataOutEn_n is high to float the data pins; dataOut keeps driving its last word.
// - About 140 ns to become active after power-down goes low.
`timescale 1ns/100ps
`include "adcop_regs.vh"
module adcop_port #(
  parameter AIN_W = `ADCOP_AIN_W,
  parameter CODE_W = `ADCOP_CODE_W,
  parameter LATENCY_HALF = `ADCOP_LATENCY_HALF,
  parameter OD_CYC = `ADCOP_OUT_DELAY_CYC,
  parameter WAKE_CYC = `ADCOP_WAKE_CYC
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Converter clock and control from the host
  input wire convClk,
  input wire powerDownPin,
  // Analog levels, as digital words
  input wire [AIN_W-1:0] analogInput,
  input wire [AIN_W-1:0] referenceTopVoltage,
  input wire [AIN_W-1:0] referenceBottomVoltage,
  // Data pins
  output wire [CODE_W-1:0] dataOut,
  output reg dataOutEn_n,
  // Status
  output reg lowPowerMode
);
  // Rising stages after the sampling fall: 2.5 cycles gives three rises
  localparam NST = (LATENCY_HALF + 1) / 2;
  localparam ST_OFF = 2'h0;
  localparam ST_WAKE = 2'h1;
  localparam ST_ACTIVE = 2'h2;
  localparam [`ADCOP_WAKE_CNT_W-1:0] WAKE_LAST = WAKE_CYC[`ADCOP_WAKE_CNT_W-1:0] - 1'b1;

  reg convClkQ;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [`ADCOP_WAKE_CNT_W-1:0] wakeCnt;
  reg [CODE_W-1:0] heldSample;
  reg [CODE_W-1:0] pipe [0:NST-1];
  reg [CODE_W-1:0] outWord;
  reg [OD_CYC-1:0] riseDly;
  wire [CODE_W-1:0] quantCode;
  wire running;
  wire convFall;
  wire convRise;
  wire outUpdate;

  // ****************************************
  // Converter clock edges
  // ****************************************
  // Pipeline is frozen while powered down, which is what saves the power
  assign running = (state != ST_OFF);
  assign convFall = running & convClkQ & ~convClk;
  assign convRise = running & ~convClkQ & convClk;

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      convClkQ <= 1'b0;
    end
    else
    begin
      convClkQ <= convClk;
    end
  end

  // ****************************************
  // Sampling and pipeline
  // ****************************************
  adcop_quant #(
    .AIN_W(AIN_W),
    .CODE_W(CODE_W)
  ) uQuant (
    .analogInput(analogInput),
    .referenceTopVoltage(referenceTopVoltage),
    .referenceBottomVoltage(referenceBottomVoltage),
    .code(quantCode)
  );

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      heldSample <= `ADCOP_CODE_ZERO;
    end
    else if (convFall)
    begin
      heldSample <= quantCode;
    end
  end

  // Output update trails the rising edge by the output delay
  genvar gi;
  generate
    for (gi = 0; gi < OD_CYC; gi = gi + 1)
    begin : gDly
      always @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          riseDly[gi] <= 1'b0;
        end
        else if (gi == 0)
        begin
          riseDly[gi] <= convRise;
        end
        else
        begin
          riseDly[gi] <= riseDly[(gi > 0) ? gi - 1 : 0];
        end
      end
    end
  endgenerate
  assign outUpdate = riseDly[OD_CYC-1];

  // Every stage moves on the rise; the pins copy the last stage after the delay,
  // so the update reads the last stage after the same rise has already refilled it
  generate
    for (gi = 0; gi < NST; gi = gi + 1)
    begin : gPipe
      always @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pipe[gi] <= `ADCOP_CODE_ZERO;
        end
        else if (convRise)
        begin
          pipe[gi] <= (gi == 0) ? heldSample : pipe[(gi > 0) ? gi - 1 : 0];
        end
      end
    end
  endgenerate

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      outWord <= `ADCOP_CODE_ZERO;
    end
    else if (outUpdate)
    begin
      outWord <= pipe[NST-1];
    end
  end
  assign dataOut = outWord;

  // ****************************************
  // Power-down and wake
  // ****************************************
  always @*
  begin
    next_state = state;
    case (state)
      ST_OFF:
      begin
        if (!powerDownPin)
        begin
          next_state = ST_WAKE;
        end
      end
      ST_WAKE:
      begin
        if (powerDownPin)
        begin
          next_state = ST_OFF;
        end
        else if (wakeCnt == WAKE_LAST)
        begin
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE:
      begin
        if (powerDownPin)
        begin
          next_state = ST_OFF;
        end
      end
      default:
      begin
        next_state = ST_OFF;
      end
    endcase
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_WAKE;
      wakeCnt <= {`ADCOP_WAKE_CNT_W{1'b0}};
      dataOutEn_n <= 1'b1;
      lowPowerMode <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (next_state == ST_WAKE && state == ST_WAKE)
      begin
        wakeCnt <= wakeCnt + 1'b1;
      end
      else
      begin
        wakeCnt <= {`ADCOP_WAKE_CNT_W{1'b0}};
      end
      // Pins float until fully awake so the host never sees a half-woken word
      dataOutEn_n <= (next_state != ST_ACTIVE);
      lowPowerMode <= (next_state == ST_OFF);
    end
  end
endmodule // adcop_port

// ===== adcop_regs.vh
// Constants for the pipelined converter output port
`ifndef ADCOP_REGS_VH
`define ADCOP_REGS_VH
// ****************************************
// Word widths
// ****************************************
`define ADCOP_CODE_W 8
`define ADCOP_AIN_W 12
`define ADCOP_CODE_ZERO 8'h00
`define ADCOP_CODE_FULL 8'hFF
// ****************************************
// Timing
// ****************************************
`define ADCOP_CLK_PERIOD_NS 50
`define ADCOP_MAX_MSPS 55
`define ADCOP_LATENCY_HALF 5
`define ADCOP_OUT_DELAY_MAX_NS 20
`define ADCOP_OUT_DELAY_CYC ((`ADCOP_OUT_DELAY_MAX_NS / `ADCOP_CLK_PERIOD_NS) > 0 ? (`ADCOP_OUT_DELAY_MAX_NS / `ADCOP_CLK_PERIOD_NS) : 1)
`define ADCOP_WAKE_NS 140
`define ADCOP_WAKE_CYC ((`ADCOP_WAKE_NS + `ADCOP_CLK_PERIOD_NS - 1) / `ADCOP_CLK_PERIOD_NS)
`define ADCOP_WAKE_CNT_W 4
`endif

// ===== adcop_quant.v
// Quantiser: input level against the reference ladder to an unsigned code
`timescale 1ns/100ps
`include "adcop_regs.vh"
module adcop_quant #(
  parameter AIN_W = `ADCOP_AIN_W,
  parameter CODE_W = `ADCOP_CODE_W
) (
  // Levels
  input wire [AIN_W-1:0] analogInput,
  input wire [AIN_W-1:0] referenceTopVoltage,
  input wire [AIN_W-1:0] referenceBottomVoltage,
  // Result
  output reg [CODE_W-1:0] code
);
  reg [AIN_W+CODE_W-1:0] num;
  reg [AIN_W+CODE_W-1:0] den;
  reg [AIN_W+CODE_W-1:0] quot;
  always @*
  begin
    num = {(analogInput - referenceBottomVoltage), {CODE_W{1'b0}}};
    den = {{CODE_W{1'b0}}, (referenceTopVoltage - referenceBottomVoltage)};
    quot = {(AIN_W+CODE_W){1'b0}};
    if (analogInput <= referenceBottomVoltage)
    begin
      code = {CODE_W{1'b0}};
    end
    else if (analogInput >= referenceTopVoltage)
    begin
      code = {CODE_W{1'b1}};
    end
    else
    begin
      // Straight binary, scaled across the ladder span
      quot = num / den;
      if (quot[AIN_W+CODE_W-1:CODE_W] != {AIN_W{1'b0}})
      begin
        code = {CODE_W{1'b1}};
      end
      else
      begin
        code = quot[CODE_W-1:0];
      end
    end
  end
endmodule // adcop_quant

// ===== adcop_port_asserts.sv
// Port checker for the converter output
`timescale 1ns/100ps
module adcop_port_asserts #(parameter AIN_W = 12, CODE_W = 8) (
  // Clock
  input wire ref_clk,
  input wire rst_n,
  // Inputs
  input wire convClk,
  input wire powerDownPin,
  input wire [AIN_W-1:0] analogInput,
  input wire [AIN_W-1:0] referenceTopVoltage,
  input wire [AIN_W-1:0] referenceBottomVoltage,
  // Outputs
  input wire [CODE_W-1:0] dataOut,
  input wire dataOutEn_n,
  input wire lowPowerMode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_lpOn; powerDownPin |=> lowPowerMode; endproperty
  a_lpOn: assert property (p_lpOn) else $error("lp on");
  property p_lpOff; !powerDownPin |=> !lowPowerMode; endproperty
  a_lpOff: assert property (p_lpOff) else $error("lp off");
  property p_hiZ; powerDownPin |=> dataOutEn_n; endproperty
  a_hiZ: assert property (p_hiZ) else $error("hi-z");
  property p_wait; $fell(lowPowerMode) |-> dataOutEn_n[*3]; endproperty
  a_wait: assert property (p_wait) else $error("early");
  property p_wake; $fell(lowPowerMode) ##0 !powerDownPin[*3] |=> !dataOutEn_n; endproperty
  a_wake: assert property (p_wake) else $error("late");
  property p_en; !dataOutEn_n |-> !$past(powerDownPin) && !$past(powerDownPin, 3); endproperty
  a_en: assert property (p_en) else $error("en");
  property p_upd; $changed(dataOut) |-> $past(convClk, 2) && !$past(convClk, 3); endproperty
  a_upd: assert property (p_upd) else $error("upd");
  property p_hold; lowPowerMode[*3] |-> $stable(dataOut); endproperty
  a_hold: assert property (p_hold) else $error("hold");
endmodule // adcop_port_asserts

// ===== adcop_host_model.sv
// Host model: converter clock, power-down, word capture
`timescale 1ns/100ps
module adcop_host_model (
  // Control
  input wire ref_clk,
  input wire slow,
  input wire pdReq,
  // Device pins
  input wire [7:0] dataOut,
  input wire dataOutEn_n,
  output reg convClk = 1'b0,
  output reg powerDownPin,
  // Captured words
  output reg [7:0] capWord = 8'h00,
  output reg capValid = 1'b0
);
  reg [1:0] phase = 2'h0;
  reg [2:0] skip = 3'h7;
  wire flip = phase >= (slow ? 2'h2 : 2'h0);
  always @*
    powerDownPin = pdReq;
  always @(negedge ref_clk)
  begin
    phase <= flip ? 2'h0 : phase + 2'h1;
    convClk <= flip ? ~convClk : convClk;
  end
  // Rising edge only: words move near the falling edge
  always @(posedge convClk)
  begin
    capValid <= !dataOutEn_n && skip == 3'h0;
    capWord <= dataOut;
    skip <= (powerDownPin || dataOutEn_n) ? 3'h4 : skip - {2'h0, skip != 3'h0};
  end
endmodule // adcop_host_model

// ===== adcop_port_tb.sv
// Self-checking bench for the converter output port
`timescale 1ns/100ps
module adcop_port_tb;
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg slow = 1'b0;
  reg pdReq = 1'b0;
  reg [11:0] ain = 12'h000;
  reg [11:0] top = 12'hC00;
  reg [11:0] bot = 12'h400;
  reg [7:0] prevExp = 8'h00;
  reg [43:0] rows [0:7];
  wire convClk, powerDownPin, dataOutEn_n, lowPowerMode, capValid;
  wire [7:0] dataOut, capWord;
  integer errors = 0;
  integer samples_checked = 0;
  integer i;
  always #25 ref_clk = ~ref_clk;
  adcop_port i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .convClk(convClk),
    .powerDownPin(powerDownPin), .analogInput(ain), .referenceTopVoltage(top),
    .referenceBottomVoltage(bot), .dataOut(dataOut), .dataOutEn_n(dataOutEn_n),
    .lowPowerMode(lowPowerMode));
  adcop_host_model i_host (.ref_clk(ref_clk), .slow(slow), .pdReq(pdReq),
    .dataOut(dataOut), .dataOutEn_n(dataOutEn_n), .convClk(convClk),
    .powerDownPin(powerDownPin), .capWord(capWord), .capValid(capValid));
  task check(input [7:0] got, input [7:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task summarize;
  begin
    $display("Checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  // Twenty times the expected run
  initial
  begin
    #200000;
    errors = errors + 1;
    summarize;
  end
  initial
  begin
    rows = '{44'h100_C00_400_00, 44'h800_C00_400_80, 44'h408_C00_400_01, 44'hFFF_C00_400_FF,
      44'h407_C00_400_00, 44'hBFF_C00_400_FF, 44'h180_200_100_80, 44'h400_C00_400_00};
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    // New value taken at a fall shows one output delay after the third rise, so the third-rise check still sees the old word
    for (i = 0; i < 8; i = i + 1)
    begin
      slow = i[0];
      @(negedge convClk);
      {ain, top, bot} = rows[i][43:8];
      repeat (3) @(posedge convClk);
      #1 check(dataOut, prevExp);
      @(posedge convClk);
      #1 check(dataOut, rows[i][7:0]);
      prevExp = rows[i][7:0];
      $display("Row %0d done", i);
    end
    @(negedge ref_clk);
    pdReq = 1'b1;
    ain = 12'hFFF;
    @(negedge ref_clk);
    check({6'h00, lowPowerMode, dataOutEn_n}, 8'h03);
    repeat (12) @(negedge ref_clk);
    check(dataOut, prevExp);
    pdReq = 1'b0;
    repeat (3) @(negedge ref_clk);
    check({7'h00, dataOutEn_n}, 8'h01);
    @(negedge ref_clk);
    check({7'h00, dataOutEn_n}, 8'h00);
    i = 0;
    while (capValid !== 1'b1 && i < 60)
      @(negedge ref_clk) i = i + 1;
    check({7'h00, capValid}, 8'h01);
    check(capWord, 8'hFF);
    $display("Power-down done");
    rst_n = 1'b0;
    @(negedge ref_clk);
    check(dataOut, 8'h00);
    check({6'h00, lowPowerMode, dataOutEn_n}, 8'h01);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    check({7'h00, dataOutEn_n}, 8'h01);
    @(negedge ref_clk);
    check({7'h00, dataOutEn_n}, 8'h00);
    $display("Reset done");
    summarize;
  end
endmodule // adcop_port_tb
bind adcop_port adcop_port_asserts #(.AIN_W(AIN_W), .CODE_W(CODE_W)) i_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .convClk(convClk), .powerDownPin(powerDownPin),
  .analogInput(analogInput), .referenceTopVoltage(referenceTopVoltage),
  .referenceBottomVoltage(referenceBottomVoltage), .dataOut(dataOut),
  .dataOutEn_n(dataOutEn_n), .lowPowerMode(lowPowerMode));
